/* dsau_agu.sv */
// Address generator: effective address and next pointer for one access path.
// Assumes the request is stable for the cycle in which it is valid.
`timescale 1ns/1ps
module dsau_agu #(
  parameter bit BREV_OK = 1'b0
) (
  input wire dsau_pkg::dsau_req_t req_in,
  input wire dsau_pkg::dsau_mod_t mod_in,
  input wire dsau_pkg::dsau_brev_t brev_in,
  output logic [15:0] ea_out,
  output logic [15:0] ptr_nxt_out
);
  function automatic logic [15:0] rev16(input logic [15:0] v);
    logic [15:0] r;
    r = '0;
    for (int i = 0; i < 16; i++) begin
      r[i] = v[15-i];
    end
    return r;
  endfunction : rev16

  logic [15:0] step;

  always_comb begin
    step = req_in.byte_op ? dsau_pkg::STEP_BYTE : dsau_pkg::STEP_WORD;
    if (req_in.mode == dsau_pkg::AM_NEAR) begin
      ea_out = {3'h0, req_in.addr[dsau_pkg::NEAR_W-1:0]};
    end else begin
      ea_out = req_in.addr;
    end
    ptr_nxt_out = req_in.addr;
    if (req_in.mode == dsau_pkg::AM_IND && req_in.post_inc) begin
      // Reverse-carry add walks the pointer in bit-reversed order.
      if (BREV_OK && brev_in.en && !req_in.byte_op) begin
        ptr_nxt_out = rev16(rev16(req_in.addr) + rev16(brev_in.step));
      end else if (mod_in.en && req_in.addr[15:1] == mod_in.stop[15:1]) begin
        ptr_nxt_out = mod_in.start;
      end else begin
        ptr_nxt_out = req_in.addr + step;
      end
    end
  end
endmodule : dsau_agu

/* dsau_pkg.sv */
// Constants, types and carriers shared by the data space access unit files.
// Assumes one core clock and a synchronous, active-high system reset.
// Overview of operation
// - Effective addresses are 16-bit byte addresses.
// - Read/write page selects extend addresses to 16 Mbytes.
// - Accesses outside implemented area return zero.
// - Even byte is low lane, odd is high.
// - Post-increment steps 1 for bytes, 2 for words.
// - Byte reads fetch word, address bit selects byte.
// - Byte writes strobe only the matching lane.
// - Odd-address word accesses raise address error.
// - Misaligned read completes; misaligned write is suppressed.
// - Byte register loads keep the high byte.
// - Provide sign-widen and zero-widen operations.
// - Lowest 4 Kbytes are control registers; unused read zero.
// - Direct instructions reach low 8 Kbytes via 13 bits.
// - Full space reachable via 16-bit direct or pointer.
// - Separate read and write address generators.
// - X read bus serves combined space and prefetch.
// - Y read path runs concurrently with X read.
// - Modulo on X and Y; bit-reverse only X writes.
// - Writes decode combined map; fixed X/Y split.
// - Stack frame active makes frame/stack pointers ignore pages.
package dsau_pkg;
  localparam int EA_W = 16;
  localparam int PAGE_W = 9;
  localparam int EXT_W = 24;
  localparam int NEAR_W = 13;
  localparam int RAM_AW = 13;
  localparam int SFR_AW = 12;
  localparam logic [23:0] SFR_END = 24'h001000;
  localparam logic [23:0] IMPL_END = 24'h005000;
  localparam logic [23:0] Y_BASE = 24'h003000;
  localparam logic [15:0] STEP_BYTE = 16'h0001;
  localparam logic [15:0] STEP_WORD = 16'h0002;

  typedef enum logic [1:0] {
    AM_NEAR = 2'b00,
    AM_FULL = 2'b01,
    AM_IND = 2'b10
  } dsau_amode_t;

  typedef enum logic [1:0] {
    EXT_NONE = 2'b00,
    EXT_SIGN = 2'b01,
    EXT_ZERO = 2'b10
  } dsau_ext_t;

  typedef enum logic [1:0] {
    SRC_ZERO = 2'b00,
    SRC_SFR = 2'b01,
    SRC_RAM = 2'b10
  } dsau_src_t;

  typedef struct packed {
    logic valid;
    logic byte_op;
    dsau_amode_t mode;
    logic post_inc;
    logic frame_stack;
    logic [15:0] addr;
  } dsau_req_t;

  typedef struct packed {
    logic en;
    logic [15:0] start;
    logic [15:0] stop;
  } dsau_mod_t;

  typedef struct packed {
    logic en;
    logic [15:0] step;
  } dsau_brev_t;
endpackage : dsau_pkg

/* dsau_ram.sv */
// Data RAM: two registered word read ports and one byte-laned write port.
// Assumes addresses are word indices already decoded into the RAM region.
`timescale 1ns/1ps
module dsau_ram #(
  parameter int AW = dsau_pkg::RAM_AW
) (
  input wire logic clk_sys_in,
  input wire logic x_rd_en_in,
  input wire logic [AW-1:0] x_rd_addr_in,
  output logic [15:0] x_rd_data_out,
  input wire logic y_rd_en_in,
  input wire logic [AW-1:0] y_rd_addr_in,
  output logic [15:0] y_rd_data_out,
  input wire logic wr_en_in,
  input wire logic [1:0] wr_be_in,
  input wire logic [AW-1:0] wr_addr_in,
  input wire logic [15:0] wr_data_in
);
  // Two byte-wide arrays share one word decode but have separate write lines.
  logic [7:0] lo_mem [2**AW];
  logic [7:0] hi_mem [2**AW];

  always_ff @(posedge clk_sys_in) begin
    if (wr_en_in && wr_be_in[0]) begin
      lo_mem[wr_addr_in] <= wr_data_in[7:0];
    end
    if (wr_en_in && wr_be_in[1]) begin
      hi_mem[wr_addr_in] <= wr_data_in[15:8];
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (x_rd_en_in) begin
      x_rd_data_out <= {hi_mem[x_rd_addr_in], lo_mem[x_rd_addr_in]};
    end
    if (y_rd_en_in) begin
      y_rd_data_out <= {hi_mem[y_rd_addr_in], lo_mem[y_rd_addr_in]};
    end
  end
endmodule : dsau_ram

/* dsau_sfr_model.sv */
// Behavioural control register block that answers the unit's reads.
// Assumes reads are answered in the same cycle as the read enable.
`timescale 1ns/1ps
module dsau_sfr_model (
  input wire logic clk_sys_in,
  input wire logic sys_rst_in,
  input wire logic rd_en_in,
  input wire logic [11:0] rd_addr_in,
  output logic [15:0] rd_data_out,
  output logic rd_ack_out
);
  // --------------------------------------------------------------
  // Answer logic
  // --------------------------------------------------------------
  logic [15:0] junk_r;
  logic hit;
  // Idle data churns every cycle so a stale capture never looks right.
  always_ff @(posedge clk_sys_in) begin
    if (sys_rst_in) begin
      junk_r <= 16'h5a5a;
    end else begin
      junk_r <= {junk_r[14:0], ~junk_r[15]};
    end
  end
  assign hit = rd_en_in && (rd_addr_in[11:8] == 4'h0);
  assign rd_ack_out = hit;
  assign rd_data_out = hit ? {rd_addr_in[11:1], 5'h0b} : junk_r;
endmodule : dsau_sfr_model

/* dsau_top.sv */
// Data space access unit: paging, decode, byte lanes and address errors.
// Assumes the pipeline holds page selects and the stack frame flag, and that
// the control register block answers a read in the same cycle.
`timescale 1ns/1ps
module dsau_top #(
  parameter int RAM_AW = dsau_pkg::RAM_AW
) (
  input wire logic clk_sys_in,
  input wire logic sys_rst_in,
  input wire logic stack_frame_active_in,
  input wire logic [dsau_pkg::PAGE_W-1:0] read_page_select_in,
  input wire logic [dsau_pkg::PAGE_W-1:0] write_page_select_in,
  input wire dsau_pkg::dsau_mod_t x_mod_in,
  input wire dsau_pkg::dsau_mod_t y_mod_in,
  input wire dsau_pkg::dsau_brev_t x_brev_in,
  input wire dsau_pkg::dsau_req_t x_rd_req_in,
  input wire logic x_rd_load_reg_in,
  input wire logic [15:0] x_rd_dest_old_in,
  input wire dsau_pkg::dsau_req_t y_rd_req_in,
  input wire dsau_pkg::dsau_req_t wr_req_in,
  input wire logic [15:0] wr_data_in,
  input wire logic [15:0] sfr_rd_data_in,
  input wire logic sfr_rd_ack_in,
  input wire dsau_pkg::dsau_ext_t ext_op_in,
  input wire logic [15:0] ext_val_in,
  output logic [15:0] x_rdata_out,
  output logic x_rvalid_out,
  output logic [15:0] y_rdata_out,
  output logic y_rvalid_out,
  output logic [15:0] x_rd_ptr_nxt_out,
  output logic [15:0] y_rd_ptr_nxt_out,
  output logic [15:0] wr_ptr_nxt_out,
  output logic [23:0] rd_ext_addr_out,
  output logic [23:0] wr_ext_addr_out,
  output logic addr_err_out,
  output logic addr_err_write_out,
  output logic sfr_rd_en_out,
  output logic [dsau_pkg::SFR_AW-1:0] sfr_rd_addr_out,
  output logic sfr_wr_en_out,
  output logic [1:0] sfr_wr_be_out,
  output logic [dsau_pkg::SFR_AW-1:0] sfr_wr_addr_out,
  output logic [15:0] sfr_wr_data_out,
  output logic [15:0] ext_result_out
);
  // ---------------------------------------------------------------------
  // Address generation
  // ---------------------------------------------------------------------
  logic [15:0] x_ea;
  logic [15:0] y_ea;
  logic [15:0] w_ea;
  logic [15:0] x_nxt;
  logic [15:0] y_nxt;
  logic [15:0] w_nxt;

  // Separate generators let a read and a write proceed in one cycle.
  dsau_agu #(.BREV_OK(1'b0)) u_agu_xrd (
    .req_in(x_rd_req_in),
    .mod_in(x_mod_in),
    .brev_in(x_brev_in),
    .ea_out(x_ea),
    .ptr_nxt_out(x_nxt)
  );

  dsau_agu #(.BREV_OK(1'b0)) u_agu_yrd (
    .req_in(y_rd_req_in),
    .mod_in(y_mod_in),
    .brev_in(x_brev_in),
    .ea_out(y_ea),
    .ptr_nxt_out(y_nxt)
  );

  dsau_agu #(.BREV_OK(1'b1)) u_agu_wr (
    .req_in(wr_req_in),
    .mod_in(x_mod_in),
    .brev_in(x_brev_in),
    .ea_out(w_ea),
    .ptr_nxt_out(w_nxt)
  );

  // ---------------------------------------------------------------------
  // Paging and decode
  // ---------------------------------------------------------------------
  function automatic logic [23:0] extend(input logic [15:0] ea,
                                         input logic [dsau_pkg::PAGE_W-1:0] page,
                                         input logic flat);
    if (flat || !ea[15]) begin
      return {8'h00, ea};
    end
    return {page, ea[14:0]};
  endfunction : extend

  logic x_flat;
  logic y_flat;
  logic w_flat;
  logic [23:0] x_ext;
  logic [23:0] y_ext;
  logic [23:0] w_ext;
  logic [23:0] x_off;
  logic [23:0] y_off;
  logic [23:0] w_off;
  logic x_in_sfr;
  logic x_in_ram;
  logic y_in_ram;
  logic w_in_sfr;
  logic w_in_ram;
  logic x_mis;
  logic y_mis;
  logic w_mis;
  logic w_go;
  logic [1:0] w_be;
  logic [15:0] w_lane_data;

  always_comb begin
    x_flat = stack_frame_active_in && x_rd_req_in.frame_stack;
    y_flat = stack_frame_active_in && y_rd_req_in.frame_stack;
    w_flat = stack_frame_active_in && wr_req_in.frame_stack;
    x_ext = extend(x_ea, read_page_select_in, x_flat);
    y_ext = extend(y_ea, read_page_select_in, y_flat);
    w_ext = extend(w_ea, write_page_select_in, w_flat);
    x_off = x_ext - dsau_pkg::SFR_END;
    y_off = y_ext - dsau_pkg::SFR_END;
    w_off = w_ext - dsau_pkg::SFR_END;
    x_in_sfr = x_ext < dsau_pkg::SFR_END;
    x_in_ram = !x_in_sfr && x_ext < dsau_pkg::IMPL_END;
    // The X/Y split is a fixed constant; software cannot move it.
    y_in_ram = y_ext >= dsau_pkg::Y_BASE && y_ext < dsau_pkg::IMPL_END;
    w_in_sfr = w_ext < dsau_pkg::SFR_END;
    w_in_ram = !w_in_sfr && w_ext < dsau_pkg::IMPL_END;
    x_mis = x_rd_req_in.valid && !x_rd_req_in.byte_op && x_ea[0];
    y_mis = y_rd_req_in.valid && y_ea[0];
    w_mis = wr_req_in.valid && !wr_req_in.byte_op && w_ea[0];
    w_go = wr_req_in.valid && !w_mis;
    if (!wr_req_in.byte_op) begin
      w_be = 2'h3;
    end else if (w_ea[0]) begin
      w_be = 2'h2;
    end else begin
      w_be = 2'h1;
    end
    w_lane_data = wr_req_in.byte_op ? {wr_data_in[7:0], wr_data_in[7:0]} : wr_data_in;
  end

  // ---------------------------------------------------------------------
  // Control register read port
  // ---------------------------------------------------------------------
  always_comb begin
    sfr_rd_en_out = x_rd_req_in.valid && x_in_sfr;
    sfr_rd_addr_out = x_ext[dsau_pkg::SFR_AW-1:0];
  end

  // ---------------------------------------------------------------------
  // Write stage
  // ---------------------------------------------------------------------
  logic w_ram_we_r;
  logic [RAM_AW-1:0] w_ram_addr_r;
  logic [1:0] w_be_r;
  logic [15:0] w_data_r;

  always_ff @(posedge clk_sys_in) begin
    if (sys_rst_in) begin
      w_ram_we_r <= 1'b0;
      sfr_wr_en_out <= 1'b0;
      w_ram_addr_r <= '0;
      w_be_r <= 2'h0;
      w_data_r <= 16'h0000;
      wr_ext_addr_out <= 24'h000000;
      wr_ptr_nxt_out <= 16'h0000;
    end else begin
      // A misaligned write still retires, but nothing reaches memory.
      w_ram_we_r <= w_go && w_in_ram;
      sfr_wr_en_out <= w_go && w_in_sfr;
      w_ram_addr_r <= w_off[RAM_AW:1];
      w_be_r <= w_be;
      w_data_r <= w_lane_data;
      if (wr_req_in.valid) begin
        wr_ext_addr_out <= w_ext;
        wr_ptr_nxt_out <= w_nxt;
      end
    end
  end

  always_comb begin
    sfr_wr_be_out = w_be_r;
    sfr_wr_addr_out = wr_ext_addr_out[dsau_pkg::SFR_AW-1:0];
    sfr_wr_data_out = w_data_r;
  end

  // ---------------------------------------------------------------------
  // Memory
  // ---------------------------------------------------------------------
  logic [15:0] ram_x_data;
  logic [15:0] ram_y_data;

  dsau_ram #(.AW(RAM_AW)) u_ram (
    .clk_sys_in(clk_sys_in),
    .x_rd_en_in(x_rd_req_in.valid && x_in_ram),
    .x_rd_addr_in(x_off[RAM_AW:1]),
    .x_rd_data_out(ram_x_data),
    .y_rd_en_in(y_rd_req_in.valid && y_in_ram),
    .y_rd_addr_in(y_off[RAM_AW:1]),
    .y_rd_data_out(ram_y_data),
    .wr_en_in(w_ram_we_r),
    .wr_be_in(w_be_r),
    .wr_addr_in(w_ram_addr_r),
    .wr_data_in(w_data_r)
  );

  // ---------------------------------------------------------------------
  // Read stage
  // ---------------------------------------------------------------------
  dsau_pkg::dsau_src_t x_src_r;
  logic x_byte_r;
  logic x_hi_r;
  logic x_load_r;
  logic [7:0] x_old_hi_r;
  logic [15:0] sfr_data_r;
  logic y_ram_r;

  always_ff @(posedge clk_sys_in) begin
    if (sys_rst_in) begin
      x_rvalid_out <= 1'b0;
      x_src_r <= dsau_pkg::SRC_ZERO;
      x_byte_r <= 1'b0;
      x_hi_r <= 1'b0;
      x_load_r <= 1'b0;
      x_old_hi_r <= 8'h00;
      sfr_data_r <= 16'h0000;
      rd_ext_addr_out <= 24'h000000;
      x_rd_ptr_nxt_out <= 16'h0000;
    end else begin
      // A misaligned read is not cancelled; the instruction completes.
      x_rvalid_out <= x_rd_req_in.valid;
      if (x_rd_req_in.valid) begin
        if (x_in_sfr) begin
          x_src_r <= dsau_pkg::SRC_SFR;
        end else if (x_in_ram) begin
          x_src_r <= dsau_pkg::SRC_RAM;
        end else begin
          x_src_r <= dsau_pkg::SRC_ZERO;
        end
        x_byte_r <= x_rd_req_in.byte_op;
        x_hi_r <= x_ea[0];
        x_load_r <= x_rd_load_reg_in;
        x_old_hi_r <= x_rd_dest_old_in[15:8];
        sfr_data_r <= sfr_rd_ack_in ? sfr_rd_data_in : 16'h0000;
        rd_ext_addr_out <= x_ext;
        x_rd_ptr_nxt_out <= x_nxt;
      end
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (sys_rst_in) begin
      y_rvalid_out <= 1'b0;
      y_ram_r <= 1'b0;
      y_rd_ptr_nxt_out <= 16'h0000;
    end else begin
      y_rvalid_out <= y_rd_req_in.valid;
      if (y_rd_req_in.valid) begin
        y_ram_r <= y_in_ram;
        y_rd_ptr_nxt_out <= y_nxt;
      end
    end
  end

  logic [15:0] x_word;
  logic [7:0] x_sel;

  // The X read bus carries every combined-space read and the X prefetch.
  always_comb begin
    unique case (x_src_r)
      dsau_pkg::SRC_SFR: x_word = sfr_data_r;
      dsau_pkg::SRC_RAM: x_word = ram_x_data;
      default: x_word = 16'h0000;
    endcase
    x_sel = x_hi_r ? x_word[15:8] : x_word[7:0];
    if (!x_byte_r) begin
      x_rdata_out = x_word;
    end else if (x_load_r) begin
      x_rdata_out = {x_old_hi_r, x_sel};
    end else begin
      x_rdata_out = {8'h00, x_sel};
    end
    y_rdata_out = y_ram_r ? ram_y_data : 16'h0000;
  end

  // ---------------------------------------------------------------------
  // Address error report
  // ---------------------------------------------------------------------
  always_ff @(posedge clk_sys_in) begin
    if (sys_rst_in) begin
      addr_err_out <= 1'b0;
      addr_err_write_out <= 1'b0;
    end else begin
      addr_err_out <= x_mis || y_mis || w_mis;
      addr_err_write_out <= w_mis;
    end
  end

  // ---------------------------------------------------------------------
  // Widen operations
  // ---------------------------------------------------------------------
  always_ff @(posedge clk_sys_in) begin
    if (sys_rst_in) begin
      ext_result_out <= 16'h0000;
    end else begin
      unique case (ext_op_in)
        dsau_pkg::EXT_SIGN: ext_result_out <= {{8{ext_val_in[7]}}, ext_val_in[7:0]};
        dsau_pkg::EXT_ZERO: ext_result_out <= {8'h00, ext_val_in[7:0]};
        default: ext_result_out <= ext_result_out;
      endcase
    end
  end

  // ---------------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------------
  default clocking cb @(posedge clk_sys_in);
  endclocking
  default disable iff (sys_rst_in);

  sequence s_mis_wr;
    wr_req_in.valid && !wr_req_in.byte_op && w_ea[0];
  endsequence
  sequence s_trap_wr;
    addr_err_out && addr_err_write_out && !sfr_wr_en_out && !w_ram_we_r;
  endsequence

  property p_zero_outside;
    x_rd_req_in.valid && !x_in_sfr && !x_in_ram && !x_rd_load_reg_in
      |=> x_rvalid_out && x_rdata_out == 16'h0000;
  endproperty
  a_zero_outside: assert property (p_zero_outside) else $error("read outside map not zero");

  property p_flat_stack;
    x_rd_req_in.valid && x_rd_req_in.frame_stack && stack_frame_active_in
      |=> rd_ext_addr_out == {8'h00, $past(x_ea)};
  endproperty
  a_flat_stack: assert property (p_flat_stack) else $error("frame pointer used a page");

  property p_page_read;
    x_rd_req_in.valid && !x_flat && x_ea[15]
      |=> rd_ext_addr_out[23:15] == $past(read_page_select_in);
  endproperty
  a_page_read: assert property (p_page_read) else $error("read page not applied");

  property p_mis_write;
    s_mis_wr |=> s_trap_wr;
  endproperty
  a_mis_write: assert property (p_mis_write) else $error("misaligned write not trapped");

  property p_trap_pulse;
    addr_err_out && !$past(x_mis || y_mis || w_mis, 1) |-> 1'b0;
  endproperty
  a_trap_pulse: assert property (p_trap_pulse) else $error("trap without a cause");

  property p_byte_lane;
    wr_req_in.valid && wr_req_in.byte_op && w_in_sfr
      |=> sfr_wr_en_out && sfr_wr_be_out == ($past(w_ea[0]) ? 2'h2 : 2'h1);
  endproperty
  a_byte_lane: assert property (p_byte_lane) else $error("byte write lane wrong");

  property p_post_inc;
    x_rd_req_in.valid && x_rd_req_in.mode == dsau_pkg::AM_IND && x_rd_req_in.post_inc
      && (!x_mod_in.en || x_rd_req_in.addr[15:1] != x_mod_in.stop[15:1])
      |=> x_rd_ptr_nxt_out ==
      $past(x_rd_req_in.addr) + ($past(x_rd_req_in.byte_op) ? 16'h0001 : 16'h0002);
  endproperty
  a_post_inc: assert property (p_post_inc) else $error("post increment step wrong");

  property p_sign_widen;
    ext_op_in == dsau_pkg::EXT_SIGN
      |=> ext_result_out[15:8] == {8{$past(ext_val_in[7])}};
  endproperty
  a_sign_widen: assert property (p_sign_widen) else $error("sign widen wrong");

  property p_load_keep;
    x_rd_req_in.valid && x_rd_req_in.byte_op && x_rd_load_reg_in
      |=> x_rdata_out[15:8] == $past(x_rd_dest_old_in[15:8]);
  endproperty
  a_load_keep: assert property (p_load_keep) else $error("register high byte lost");

  property p_byte_upper;
    x_rd_req_in.valid && x_rd_req_in.byte_op && !x_rd_load_reg_in
      |=> x_rdata_out[15:8] == 8'h00;
  endproperty
  a_byte_upper: assert property (p_byte_upper) else $error("byte read upper not zero");

  property p_near;
    x_rd_req_in.valid && x_rd_req_in.mode == dsau_pkg::AM_NEAR
      |=> rd_ext_addr_out == {11'h000, $past(x_rd_req_in.addr[12:0])};
  endproperty
  a_near: assert property (p_near) else $error("near address out of range");
endmodule : dsau_top

/* tb_top.sv */
// Self-checking bench for the data space access unit.
// Assumes the control register model answers reads in the same cycle.
`timescale 1ns/1ps
module tb_top;
  // --------------------------------------------------------------
  // Signals
  // --------------------------------------------------------------
  logic clk_sys_in, sys_rst_in, stack_frame_active_in, x_rd_load_reg_in, ld_nx;
  logic [dsau_pkg::PAGE_W-1:0] read_page_select_in, write_page_select_in;
  dsau_pkg::dsau_mod_t x_mod_in, y_mod_in;
  dsau_pkg::dsau_brev_t x_brev_in;
  dsau_pkg::dsau_req_t x_rd_req_in, y_rd_req_in, wr_req_in, x_nx, y_nx, w_nx;
  logic [15:0] x_rd_dest_old_in, old_nx, wr_data_in, wd_nx, sfr_rd_data_in;
  logic [15:0] ext_val_in, ev_nx, x_rdata_out, y_rdata_out, x_rd_ptr_nxt_out;
  logic [15:0] y_rd_ptr_nxt_out, wr_ptr_nxt_out, sfr_wr_data_out, ext_result_out;
  logic sfr_rd_ack_in, x_rvalid_out, y_rvalid_out, addr_err_out, addr_err_write_out;
  logic sfr_rd_en_out, sfr_wr_en_out, ext_pend;
  logic [23:0] rd_ext_addr_out, wr_ext_addr_out;
  logic [11:0] sfr_rd_addr_out, sfr_wr_addr_out;
  logic [1:0] sfr_wr_be_out;
  dsau_pkg::dsau_ext_t ext_op_in, e_nx;
  logic [79:0] xq[$], yq[$], wq[$], eq[$], tq[$], n, g;
  logic [15:0] mem [int];
  int n_mismatch, n_compared;

  dsau_top u_dut (.clk_sys_in, .sys_rst_in, .stack_frame_active_in, .read_page_select_in,
    .write_page_select_in, .x_mod_in, .y_mod_in, .x_brev_in, .x_rd_req_in, .x_rd_load_reg_in,
    .x_rd_dest_old_in, .y_rd_req_in, .wr_req_in, .wr_data_in, .sfr_rd_data_in, .sfr_rd_ack_in,
    .ext_op_in, .ext_val_in, .x_rdata_out, .x_rvalid_out, .y_rdata_out, .y_rvalid_out,
    .x_rd_ptr_nxt_out, .y_rd_ptr_nxt_out, .wr_ptr_nxt_out, .rd_ext_addr_out, .wr_ext_addr_out,
    .addr_err_out, .addr_err_write_out, .sfr_rd_en_out, .sfr_rd_addr_out, .sfr_wr_en_out,
    .sfr_wr_be_out, .sfr_wr_addr_out, .sfr_wr_data_out, .ext_result_out);
  dsau_sfr_model u_sfr (.clk_sys_in, .sys_rst_in, .rd_en_in(sfr_rd_en_out),
    .rd_addr_in(sfr_rd_addr_out), .rd_data_out(sfr_rd_data_in), .rd_ack_out(sfr_rd_ack_in));

  initial begin
    clk_sys_in = 1'b0;
    forever #5 clk_sys_in = ~clk_sys_in;
  end

  // --------------------------------------------------------------
  // Expectation helpers
  // --------------------------------------------------------------
  function automatic logic [15:0] word_at(input logic [15:0] a);
    if (a[15:12] == 4'h0) return (a[11:8] == 4'h0) ? {a[11:1], 5'h0b} : 16'h0000;
    if (a < 16'h5000) return mem[int'(a[15:1])];
    return 16'h0000;
  endfunction : word_at

  function automatic logic [15:0] nxt(input logic [15:0] a, input logic b, input logic [15:0] st,
                                      input logic [15:0] sp);
    return (a[15:1] == sp[15:1]) ? st : a + (b ? 16'h0001 : 16'h0002);
  endfunction : nxt

  task automatic chk(input string what, input logic [79:0] e, input logic [79:0] s);
    n_compared++;
    if (s !== e) begin
      n_mismatch++;
      $display("BAD %s expected %h seen %h", what, e, s);
    end
  endtask : chk

  task automatic take(ref logic [79:0] q[$], output logic [79:0] v);
    v = 'x;
    if (q.size() != 0) v = q.pop_front();
  endtask : take

  task automatic tick();
    @(posedge clk_sys_in);
    x_rd_req_in <= x_nx;
    y_rd_req_in <= y_nx;
    wr_req_in <= w_nx;
    wr_data_in <= wd_nx;
    x_rd_load_reg_in <= ld_nx;
    x_rd_dest_old_in <= old_nx;
    ext_op_in <= e_nx;
    ext_val_in <= ev_nx;
    x_nx = '0;
    y_nx = '0;
    w_nx = '0;
    e_nx = dsau_pkg::EXT_NONE;
  endtask : tick

  task automatic xr(input logic [15:0] a, input logic b, input logic ld, input logic fs,
                    input logic cy);
    logic [15:0] w, d, o;
    logic [23:0] e;
    o = 16'($urandom);
    w = word_at(a);
    d = b ? {ld ? o[15:8] : 8'h00, a[0] ? w[15:8] : w[7:0]} : w;
    e = (a[15] && !(fs && stack_frame_active_in)) ? {read_page_select_in, a[14:0]}
        : {8'h00, a};
    x_nx = '{1'b1, b, dsau_pkg::AM_IND, 1'b1, fs, a};
    ld_nx = ld;
    old_nx = o;
    xq.push_back({23'h0, d, nxt(a, b, 16'h1100, 16'h1104), e, !cy});
    if (!b && a[0]) eq.push_back(80'h0);
  endtask : xr

  task automatic yr(input logic [15:0] a);
    y_nx = '{1'b1, 1'b0, dsau_pkg::AM_IND, 1'b1, 1'b0, a};
    yq.push_back({48'h0, mem[int'(a[15:1])], nxt(a, 1'b0, 16'h3100, 16'h3104)});
  endtask : yr

  task automatic wr(input logic [15:0] a, input logic b, input logic [15:0] d);
    logic [15:0] v;
    logic [1:0] be;
    v = b ? {d[7:0], d[7:0]} : d;
    be = b ? (a[0] ? 2'b10 : 2'b01) : 2'b11;
    w_nx = '{1'b1, b, dsau_pkg::AM_IND, 1'b1, 1'b0, a};
    wd_nx = d;
    if (!b && a[0]) eq.push_back(80'h1);
    else if (a < 16'h1000) wq.push_back({11'h0, be, a[11:1], v, a + (b ? 16'h1 : 16'h2), 8'h00, a});
    else begin
      if (be[0]) mem[int'(a[15:1])][7:0] = v[7:0];
      if (be[1]) mem[int'(a[15:1])][15:8] = v[15:8];
    end
  endtask : wr

  // --------------------------------------------------------------
  // Result watcher
  // --------------------------------------------------------------
  always @(negedge clk_sys_in) begin
    if (sys_rst_in === 1'b0) begin
      if (x_rvalid_out === 1'b1) begin
        take(xq, n);
        g = {x_rdata_out, x_rd_ptr_nxt_out, n[0] ? rd_ext_addr_out : n[24:1], n[0]};
        chk("x read", n, g);
      end
      if (y_rvalid_out === 1'b1) begin
        take(yq, n);
        chk("y read", n, {48'h0, y_rdata_out, y_rd_ptr_nxt_out});
      end
      if (sfr_wr_en_out === 1'b1) begin
        take(wq, n);
        g = {sfr_wr_be_out, sfr_wr_addr_out[11:1], sfr_wr_data_out, wr_ptr_nxt_out, wr_ext_addr_out};
        chk("write", n, g);
      end
      if (addr_err_out === 1'b1) begin
        take(eq, n);
        chk("addr error", n, {79'h0, addr_err_write_out});
      end
      if (ext_pend) begin
        take(tq, n);
        chk("widen", n, {64'h0, ext_result_out});
      end
      ext_pend = (ext_op_in !== dsau_pkg::EXT_NONE);
    end
  end

  task automatic wrap_up();
    if (n_mismatch == 0 && n_compared > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : wrap_up

  // --------------------------------------------------------------
  // Stimulus
  // --------------------------------------------------------------
  initial begin
    logic [15:0] a, v;
    logic b;
    n_mismatch = 0;
    n_compared = 0;
    ext_pend = 1'b0;
    void'($urandom(68254));
    sys_rst_in = 1'b1;
    stack_frame_active_in = 1'b1;
    read_page_select_in = 9'($urandom) | 9'h100;
    write_page_select_in = 9'($urandom);
    x_mod_in = '{1'b1, 16'h1100, 16'h1104};
    y_mod_in = '{1'b1, 16'h3100, 16'h3104};
    x_brev_in = '0;
    x_rd_req_in = '0;
    y_rd_req_in = '0;
    wr_req_in = '0;
    x_nx = '0;
    y_nx = '0;
    w_nx = '0;
    wr_data_in = '0;
    wd_nx = '0;
    x_rd_load_reg_in = 1'b0;
    ld_nx = 1'b0;
    x_rd_dest_old_in = '0;
    old_nx = '0;
    ext_op_in = dsau_pkg::EXT_NONE;
    e_nx = dsau_pkg::EXT_NONE;
    ext_val_in = '0;
    ev_nx = '0;
    repeat (12) @(posedge clk_sys_in);
    sys_rst_in <= 1'b0;
    for (int i = 0; i < 6; i++) begin
      a = (i < 3) ? 16'h1100 + 16'(2 * i) : (i == 3) ? 16'h3000 : (i == 4) ? 16'h3104 : 16'h4ffe;
      wr(a, 1'b0, 16'($urandom));
      tick();
    end
    wr(16'h1103, 1'b1, 16'($urandom));
    tick();
    wr(16'h1100, 1'b1, 16'($urandom));
    repeat (3) tick();
    for (int i = 0; i < 6; i++) begin
      a = (i == 0) ? 16'h1100 : (i == 1) ? 16'h1104 : (i == 2) ? 16'h4ffe : (i == 3) ? 16'h5000
          : (i == 4) ? 16'h1103 : 16'h1100;
      xr(a, i > 3, i == 5, 1'b0, 1'b0);
      tick();
    end
    xr(16'h1102, 1'b0, 1'b0, 1'b0, 1'b1);
    yr(16'h3000);
    tick();
    xr(16'h1100, 1'b0, 1'b0, 1'b0, 1'b1);
    yr(16'h3104);
    tick();
    for (int i = 0; i < 8; i++) begin
      a = {8'h00, 8'($urandom)};
      b = 1'($urandom);
      if (!b) a[0] = 1'b0;
      xr(a, b, 1'($urandom), 1'b0, 1'b0);
      tick();
    end
    xr(16'h0800, 1'b0, 1'b0, 1'b0, 1'b0);
    x_nx.mode = dsau_pkg::AM_NEAR;
    x_nx.addr[15:13] = 3'h7;
    xq[$][40:25] = 16'he800;
    tick();
    a = {1'b1, 14'($urandom), 1'b0};
    xr(a, 1'b0, 1'b0, 1'b0, 1'b0);
    tick();
    xr(a, 1'b0, 1'b0, 1'b1, 1'b0);
    tick();
    tick();
    stack_frame_active_in <= 1'b0;
    tick();
    xr(a, 1'b0, 1'b0, 1'b1, 1'b0);
    tick();
    for (int i = 0; i < 6; i++) begin
      a = {4'h0, 12'($urandom)};
      b = 1'($urandom);
      if (!b) a[0] = 1'b0;
      wr(a, b, 16'($urandom));
      tick();
    end
    wr(16'h0005, 1'b0, 16'($urandom));
    tick();
    x_brev_in <= '{1'b1, 16'h0008};
    wr(16'h0018, 1'b0, 16'($urandom));
    wq[$][39:24] = 16'h0014;
    tick();
    xr(16'h0043, 1'b0, 1'b0, 1'b0, 1'b0);
    tick();
    for (int i = 0; i < 4; i++) begin
      v = (i == 0) ? 16'h0080 : 16'($urandom);
      e_nx = (i < 2) ? dsau_pkg::EXT_SIGN : dsau_pkg::EXT_ZERO;
      ev_nx = v;
      tq.push_back({64'h0, (i < 2) ? {{8{v[7]}}, v[7:0]} : {8'h00, v[7:0]}});
      tick();
    end
    repeat (6) tick();
    n = 80'(xq.size() + yq.size() + wq.size() + eq.size() + tq.size());
    chk("leftover", 80'h0, n);
    wrap_up();
  end
endmodule : tb_top
